/* File: include/ilcd_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Each handshake line is active low and has a single driver; the interface has no open-drain wiring.
interface ilcd_bus_if;
  logic [7:0] dio_ctl;
  logic       dav_ctl;
  logic       atn_ctl;
  logic       ifc_ctl;
  logic       nrfd_dev;
  logic       ndac_dev;
  modport ctl (output dio_ctl, output dav_ctl, output atn_ctl, output ifc_ctl,
               input nrfd_dev, input ndac_dev);
  modport dev (input dio_ctl, input dav_ctl, input atn_ctl, input ifc_ctl,
               output nrfd_dev, output ndac_dev);
endinterface
`default_nettype wire

/* File: include/ilcd_pkg.sv */
// Overview of operation
// - Unlisten with attention drops listener addressing.
// - Untalk with attention drops talker addressing.
// - Controller holds attention during unlisten and untalk.
// - Bytes without attention pass on as data only while listen addressed.
// - Device data are ASCII command character strings.
// - Commands use seven bits; compare low seven.
// - Addressed command codes: 01, 04, 08.
// - Universal command codes: 11, 14, 18, 19.
// - Listen addresses 20 to 3f, address low five.
// - Talk addresses 40 to 5f make talker.
// - Secondary command bytes are never acted on.
// - Controller drives eighth data line to zero on command bytes; data bytes keep all eight bits.
// - Addressed commands act only when listen addressed.
// - Universal commands act whenever attention is asserted.
// - Controller sends unlisten before listen address; t_data and t_ifc send listen address 3b without one.
// - Addressed sequence: unlisten, listen address, command.
// - Universal command sent with attention held throughout.
// - Listen address first, then data without attention.
// - Attention level decides command versus data.
// - Three-wire handshake transfers every byte.
// - Interface clear returns talker and listener idle.
package ilcd_pkg;
  localparam logic [6:0] ILCD_GTL_CODE   = 7'h01;
  localparam logic [6:0] ILCD_SDC_CODE   = 7'h04;
  localparam logic [6:0] ILCD_GET_CODE   = 7'h08;
  localparam logic [6:0] ILCD_LLO_CODE   = 7'h11;
  localparam logic [6:0] ILCD_DCL_CODE   = 7'h14;
  localparam logic [6:0] ILCD_SPE_CODE   = 7'h18;
  localparam logic [6:0] ILCD_SPD_CODE   = 7'h19;
  localparam logic [6:0] ILCD_UNL_CODE   = 7'h3f;
  localparam logic [6:0] ILCD_UNT_CODE   = 7'h5f;
  localparam logic [1:0] ILCD_LAG_GROUP  = 2'h1;
  localparam logic [1:0] ILCD_TAG_GROUP  = 2'h2;
  localparam logic [4:0] ILCD_ADDR_RESET = 5'h1b;
  localparam logic [7:0] ILCD_VOLTS_F    = 8'h46;
  localparam logic [7:0] ILCD_VOLTS_0    = 8'h30;
  localparam logic [7:0] ILCD_VOLTS_X    = 8'h58;
  localparam int         ILCD_BUF_DEPTH  = 2;

  typedef enum logic [3:0] {
    ILCD_CMD_NONE, ILCD_CMD_GTL, ILCD_CMD_SDC, ILCD_CMD_GET, ILCD_CMD_LLO,
    ILCD_CMD_DCL, ILCD_CMD_SPE, ILCD_CMD_SPD
  } ilcd_cmd_t;
endpackage

/* File: logic/ilcd_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module ilcd_controller
  import ilcd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  ilcd_bus_if.ctl         bus,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_atn,
  input  wire logic [7:0] req_byte,
  input  wire logic       ifc_req
);
  typedef enum logic [1:0] {ILCD_SRC_IDLE, ILCD_SRC_WAIT, ILCD_SRC_DAV, ILCD_SRC_END} ilcd_src_t;

  // ****************************************************************
  // Source handshake
  // ****************************************************************
  ilcd_src_t  st, next_st;
  logic [7:0] dio, next_dio;
  logic       atn, next_atn, dav, next_dav, ifc, next_ifc, rdy, next_rdy;

  always_comb begin
    next_st  = st;
    next_dio = dio;
    next_atn = atn;
    next_dav = dav;
    next_ifc = !ifc_req;
    next_rdy = 1'b0;
    unique case (st)
      ILCD_SRC_IDLE: begin
        next_rdy = 1'b1;
        if (req_valid && rdy) begin
          next_rdy = 1'b0;
          next_atn = !req_atn;
          next_dio = req_atn ? {1'b0, req_byte[6:0]} : req_byte;
          next_st  = ILCD_SRC_WAIT;
        end
      end
      // assert data valid only when ready and not accepted
      ILCD_SRC_WAIT: begin
        if (bus.nrfd_dev && !bus.ndac_dev) begin
          next_dav = 1'b0;
          next_st  = ILCD_SRC_DAV;
        end
      end
      ILCD_SRC_DAV: begin
        if (bus.ndac_dev) begin
          next_dav = 1'b1;
          next_st  = ILCD_SRC_END;
        end
      end
      ILCD_SRC_END: begin
        next_st = ILCD_SRC_IDLE;
      end
    endcase
    if (ifc_req) begin
      next_st  = ILCD_SRC_IDLE;
      next_dav = 1'b1;
      next_rdy = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st  <= ILCD_SRC_IDLE;
      dio <= 8'h00;
      atn <= 1'b1;
      dav <= 1'b1;
      ifc <= 1'b1;
      rdy <= 1'b0;
    end else begin
      st  <= next_st;
      dio <= next_dio;
      atn <= next_atn;
      dav <= next_dav;
      ifc <= next_ifc;
      rdy <= next_rdy;
    end
  end

  assign bus.dio_ctl = dio;
  assign bus.atn_ctl = atn;
  assign bus.dav_ctl = dav;
  assign bus.ifc_ctl = ifc;
  assign req_ready   = rdy;
endmodule
`default_nettype wire

/* File: logic/ilcd_listener.sv */
`timescale 1ns/1ps
`default_nettype none
module ilcd_listener
  import ilcd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  ilcd_bus_if.dev         bus,
  input  wire logic [4:0] my_addr,
  output logic            listen_addressed,
  output logic            talk_addressed,
  output logic [3:0]      cmd_code,
  output logic            cmd_strobe,
  output logic            dd_valid,
  input  wire logic       dd_ready,
  output logic [7:0]      dd_data
);
  typedef enum logic [1:0] {ILCD_HS_READY, ILCD_HS_TAKEN, ILCD_HS_WAIT} ilcd_hs_t;

  // ****************************************************************
  // Acceptor handshake and decode
  // ****************************************************************
  ilcd_hs_t   hs;
  ilcd_hs_t   next_hs;
  logic       lacs;
  logic       next_lacs;
  logic       tacs;
  logic       next_tacs;
  logic [3:0] cmd;
  logic [3:0] next_cmd;
  logic       stb;
  logic       next_stb;
  logic       push;
  logic       buf_ready;
  logic       take;
  logic       nrfd;
  logic       ndac;
  logic       next_nrfd;
  logic       next_ndac;
  logic [6:0] code;
  logic       fin_valid;
  logic [7:0] fin_data;

  // ****************************************************************
  // Byte classification
  // ****************************************************************
  // An address matches only inside its own group, on the low five bits.
  function automatic logic ilcd_addr_hit(input logic [6:0] c, input logic [1:0] grp,
                                         input logic [4:0] addr);
    logic hit;
    hit = (c[6:5] == grp) && (c[4:0] == addr);
    return hit;
  endfunction

  // Addressed commands use the listen flag as it stood before this byte.
  function automatic logic [3:0] ilcd_decode(input logic [6:0] c, input logic lad);
    logic [3:0] r;
    r = 4'(ILCD_CMD_NONE);
    unique case (c)
      ILCD_LLO_CODE: r = 4'(ILCD_CMD_LLO);
      ILCD_DCL_CODE: r = 4'(ILCD_CMD_DCL);
      ILCD_SPE_CODE: r = 4'(ILCD_CMD_SPE);
      ILCD_SPD_CODE: r = 4'(ILCD_CMD_SPD);
      ILCD_GTL_CODE: r = lad ? 4'(ILCD_CMD_GTL) : 4'(ILCD_CMD_NONE);
      ILCD_SDC_CODE: r = lad ? 4'(ILCD_CMD_SDC) : 4'(ILCD_CMD_NONE);
      ILCD_GET_CODE: r = lad ? 4'(ILCD_CMD_GET) : 4'(ILCD_CMD_NONE);
      default:       r = 4'(ILCD_CMD_NONE);
    endcase
    return r;
  endfunction

  assign code = bus.dio_ctl[6:0];

  // byte taken on valid data
  // A byte is taken only while ready was shown, so a full buffer holds the source off.
  assign take = (hs == ILCD_HS_READY) && !bus.dav_ctl && nrfd;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_hs   = hs;
    next_lacs = lacs;
    next_tacs = tacs;
    next_cmd  = 4'(ILCD_CMD_NONE);
    next_stb  = 1'b0;
    next_nrfd = nrfd;
    next_ndac = ndac;
    push      = 1'b0;
    unique case (hs)
      // wait for data valid with ready released
      ILCD_HS_READY: begin
        next_ndac = 1'b0;
        next_nrfd = buf_ready;
        if (take) begin
          next_hs   = ILCD_HS_TAKEN;
          next_nrfd = 1'b0;
          if (!bus.atn_ctl) begin
            if (code == ILCD_UNL_CODE) begin
              next_lacs = 1'b0;
            end else if (code[6:5] == ILCD_LAG_GROUP) begin
              if (ilcd_addr_hit(code, ILCD_LAG_GROUP, my_addr)) begin
                next_lacs = 1'b1;
              end
            end else if (code == ILCD_UNT_CODE) begin
              next_tacs = 1'b0;
            // own talk address; other talker unaddresses us
            end else if (code[6:5] == ILCD_TAG_GROUP) begin
              next_tacs = ilcd_addr_hit(code, ILCD_TAG_GROUP, my_addr);
            // only command groups decode; secondary bytes drop
            end else if (code[6:5] == 2'h0) begin
              next_cmd = ilcd_decode(code, lacs);
              next_stb = (next_cmd != 4'(ILCD_CMD_NONE));
            end
          end else if (lacs) begin
            // Room is certain here, as ready was only shown with a free entry.
            push = 1'b1;
          end
        end
      end
      // release data accepted after taking byte
      ILCD_HS_TAKEN: begin
        next_ndac = 1'b1;
        next_hs   = ILCD_HS_WAIT;
      end
      // Accepted stays high until the source drops data valid.
      ILCD_HS_WAIT: begin
        if (bus.dav_ctl) begin
          next_ndac = 1'b0;
          next_hs   = ILCD_HS_READY;
        end
      end
      default: begin
        next_hs = ILCD_HS_READY;
      end
    endcase
    // Interface clear has the last word over every update above.
    // interface clear idles both functions
    if (!bus.ifc_ctl) begin
      next_lacs = 1'b0;
      next_tacs = 1'b0;
      next_hs   = ILCD_HS_READY;
      next_ndac = 1'b0;
      next_nrfd = 1'b1;
      next_stb  = 1'b0;
      next_cmd  = 4'(ILCD_CMD_NONE);
      push      = 1'b0;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs   <= ILCD_HS_READY;
      lacs <= 1'b0;
      tacs <= 1'b0;
      cmd  <= 4'(ILCD_CMD_NONE);
      stb  <= 1'b0;
      nrfd <= 1'b1;
      ndac <= 1'b0;
    end else begin
      hs   <= next_hs;
      lacs <= next_lacs;
      tacs <= next_tacs;
      cmd  <= next_cmd;
      stb  <= next_stb;
      nrfd <= next_nrfd;
      ndac <= next_ndac;
    end
  end

  // ****************************************************************
  // Device data buffer
  // ****************************************************************
  ilcd_skid_buf ilcd_skid_buf_inst (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (bus.dio_ctl),
    .out_valid (fin_valid),
    .out_ready (dd_ready),
    .out_data  (fin_data)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bytes not meant for this device are still accepted and then dropped,
  // so the bus hangs on a device that is not listening only while its data buffer is full.
  assign dd_valid         = fin_valid;
  assign dd_data          = fin_data;
  assign bus.nrfd_dev     = nrfd;
  assign bus.ndac_dev     = ndac;
  assign listen_addressed = lacs;
  assign talk_addressed   = tacs;
  assign cmd_code         = cmd;
  assign cmd_strobe       = stb;
endmodule
`default_nettype wire

/* File: logic/ilcd_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module ilcd_skid_buf
  import ilcd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem [ILCD_BUF_DEPTH];
  logic [7:0] next_mem [ILCD_BUF_DEPTH];
  logic       rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [1:0] count, next_count;
  logic       do_wr, do_rd;
  logic       next_in_ready;
  logic       next_out_valid;
  logic [7:0] next_out_data;

  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_ready && out_valid;
    next_mem = mem;
    if (do_wr) begin
      next_mem[wr_ptr] = in_data;
    end
    next_wr_ptr    = do_wr ? ~wr_ptr : wr_ptr;
    next_rd_ptr    = do_rd ? ~rd_ptr : rd_ptr;
    next_count     = count + {1'b0, do_wr} - {1'b0, do_rd};
    // Flags and head word are registered, so both sides see flop outputs only.
    next_in_ready  = (next_count != 2'h2);
    next_out_valid = (next_count != 2'h0);
    next_out_data  = next_mem[next_rd_ptr];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem[0]    <= 8'h00;
      mem[1]    <= 8'h00;
      rd_ptr    <= 1'b0;
      wr_ptr    <= 1'b0;
      count     <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= 8'h00;
    end else begin
      mem       <= next_mem;
      rd_ptr    <= next_rd_ptr;
      wr_ptr    <= next_wr_ptr;
      count     <= next_count;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ieee488_listener_command_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ieee488_listener_command_decoder_test
  import ilcd_pkg::*;
;
  logic       clock     = 1'b0;
  logic       rst_n     = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_atn   = 1'b0;
  logic [7:0] req_byte  = 8'h00;
  logic       ifc_req   = 1'b0;
  logic       dd_ready  = 1'b1;
  logic [4:0] my_addr   = ILCD_ADDR_RESET;
  logic       req_ready, listen_addressed, talk_addressed, cmd_strobe, dd_valid;
  logic [3:0] cmd_code, last_cmd;
  logic [7:0] dd_data;
  logic [7:0] got_q[$];
  int         n_mismatch   = 0;
  int         total_checks = 0;
  int         n_strobe     = 0;
  logic [7:0] codes[7] = '{8'h01, 8'h04, 8'h08, 8'h11, 8'h14, 8'h18, 8'h19};

  always #12.5 clock = ~clock;

  ilcd_bus_if ilcd_bus_if_inst ();
  ilcd_controller ilcd_controller_inst (.clock(clock), .rst_n(rst_n), .bus(ilcd_bus_if_inst),
    .req_valid(req_valid), .req_ready(req_ready), .req_atn(req_atn), .req_byte(req_byte),
    .ifc_req(ifc_req));
  ilcd_listener ilcd_listener_inst (.clock(clock), .rst_n(rst_n), .bus(ilcd_bus_if_inst),
    .my_addr(my_addr), .listen_addressed(listen_addressed), .talk_addressed(talk_addressed),
    .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .dd_valid(dd_valid), .dd_ready(dd_ready),
    .dd_data(dd_data));
  ilcd_checker ilcd_checker_inst (.clock(clock), .rst_n(rst_n),
    .dio_ctl(ilcd_bus_if_inst.dio_ctl), .dav_ctl(ilcd_bus_if_inst.dav_ctl),
    .atn_ctl(ilcd_bus_if_inst.atn_ctl), .ifc_ctl(ilcd_bus_if_inst.ifc_ctl),
    .nrfd_dev(ilcd_bus_if_inst.nrfd_dev), .ndac_dev(ilcd_bus_if_inst.ndac_dev));

  // ****************************************
  // Capture of strobes and delivered data.
  // ****************************************
  always @(posedge clock) begin
    if (cmd_strobe === 1'b1) begin
      n_strobe++;
      last_cmd = cmd_code;
    end
    if (dd_valid === 1'b1 && dd_ready === 1'b1) got_q.push_back(dd_data);
  end

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (req_ready !== 1'b1) begin
      n_mismatch++;
      $display("wrong value req_ready expected 1 seen %b", req_ready);
    end
  endtask

  task send(input logic atn, input logic [7:0] b);
    wait_ready();
    req_atn   = atn;
    req_byte  = b;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
  endtask

  task xfer(input logic atn, input logic [7:0] b);
    send(atn, b);
    wait_ready();
    repeat (2) @(negedge clock);
  endtask

  task cmd_check(input logic [7:0] b, input int d, input int code);
    int s;
    s = n_strobe;
    xfer(1'b1, b);
    chk("strobe count", 8'(d), 8'(n_strobe - s));
    if (d > 0) chk("cmd_code", 8'(code), {4'h0, last_cmd});
  endtask

  task t_addr;
    xfer(1'b1, 8'h3f);
    xfer(1'b1, 8'h3b);
    chk("listen", 8'h01, {7'h00, listen_addressed});
    xfer(1'b1, 8'h5b);
    chk("talk", 8'h01, {7'h00, talk_addressed});
    xfer(1'b1, 8'h5f);
    chk("talk", 8'h00, {7'h00, talk_addressed});
    xfer(1'b1, 8'h5b);
    xfer(1'b1, 8'h5c);
    chk("talk", 8'h00, {7'h00, talk_addressed});
    xfer(1'b1, 8'hbf);
    chk("listen", 8'h00, {7'h00, listen_addressed});
    xfer(1'b1, 8'h3c);
    chk("listen", 8'h00, {7'h00, listen_addressed});
  endtask

  task t_cmds;
    xfer(1'b1, 8'h3f);
    xfer(1'b1, 8'h3b);
    for (int i = 0; i < 7; i++) cmd_check(codes[i], 1, i + 1);
    cmd_check(8'h7b, 0, 0);
    chk("listen", 8'h01, {7'h00, listen_addressed});
    chk("talk", 8'h00, {7'h00, talk_addressed});
    xfer(1'b1, 8'h3f);
    cmd_check(8'h04, 0, 0);
    cmd_check(8'h14, 1, 5);
  endtask

  task t_data;
    got_q.delete();
    xfer(1'b0, ILCD_VOLTS_F);
    chk("dropped count", 8'h00, 8'(got_q.size()));
    xfer(1'b1, 8'h3b);
    dd_ready = 1'b0;
    send(1'b0, ILCD_VOLTS_F);
    send(1'b0, ILCD_VOLTS_0);
    send(1'b0, ILCD_VOLTS_X);
    repeat (20) @(negedge clock);
    chk("held count", 8'h00, 8'(got_q.size()));
    chk("dd_valid", 8'h01, {7'h00, dd_valid});
    dd_ready = 1'b1;
    wait_ready();
    repeat (4) @(negedge clock);
    chk("data count", 8'h03, 8'(got_q.size()));
    chk("data 0", 8'h46, got_q[0]);
    chk("data 1", 8'h30, got_q[1]);
    chk("data 2", 8'h58, got_q[2]);
  endtask

  task t_ifc;
    xfer(1'b1, 8'h5b);
    ifc_req = 1'b1;
    repeat (3) @(negedge clock);
    ifc_req = 1'b0;
    repeat (3) @(negedge clock);
    chk("listen", 8'h00, {7'h00, listen_addressed});
    chk("talk", 8'h00, {7'h00, talk_addressed});
    xfer(1'b1, 8'h3b);
    chk("listen", 8'h01, {7'h00, listen_addressed});
  endtask

  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_addr();
    t_cmds();
    t_data();
    t_ifc();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire

/* File: testbench/ilcd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Handshake checks on the shared bus.
// ****************************************
module ilcd_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] dio_ctl,
  input wire logic       dav_ctl,
  input wire logic       atn_ctl,
  input wire logic       ifc_ctl,
  input wire logic       nrfd_dev,
  input wire logic       ndac_dev
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !ifc_ctl);
  sequence take_s;
    $fell(dav_ctl);
  endsequence
  sequence accept_s;
    ##[1:10] ndac_dev;
  endsequence
  src_waits_ready_a:
    assert property (take_s |-> $past(nrfd_dev) && !$past(ndac_dev))
    else $error("data valid raised while acceptor not ready");
  acc_busy_a:
    assert property (take_s |-> ##[1:3] !nrfd_dev)
    else $error("acceptor kept ready after taking a byte");
  acc_accept_a:
    assert property (take_s |-> accept_s)
    else $error("byte never accepted");
  accept_in_valid_a:
    assert property ($rose(ndac_dev) |-> !dav_ctl)
    else $error("accepted released without valid data");
  dav_held_a:
    assert property (!dav_ctl && !ndac_dev |=> !dav_ctl)
    else $error("data valid dropped before acceptance");
  byte_steady_a:
    assert property (!dav_ctl |=> dav_ctl || ($stable(dio_ctl) && $stable(atn_ctl)))
    else $error("byte or attention changed during transfer");
  accept_reset_a:
    assert property ($rose(dav_ctl) |-> ##[0:3] !ndac_dev)
    else $error("accepted not returned low after valid released");
  cmd_bit7_a:
    assert property (!atn_ctl && !dav_ctl |-> !dio_ctl[7])
    else $error("eighth data line set on a command byte");
  clear_idle_a:
    assert property (disable iff (!rst_n) !ifc_ctl ##1 !ifc_ctl |-> !ndac_dev)
    else $error("handshake not reset by interface clear");
endmodule
`default_nettype wire
